// file: rtl/i2c_evt_regs.svh
// Register offsets, field positions and reset values of the event flag block.
// Included by bare name; holds definitions only.
`ifndef I2C_EVT_REGS_SVH
`define I2C_EVT_REGS_SVH
`define OFS_MASK      8'h2C
`define OFS_RAW       8'h30
`define OFS_ISTAT     8'h34
`define OFS_CLR       8'h38
`define OFS_CTRL      8'h3C
`define OFS_STAT      8'h40
`define B_MD          15
`define B_SLAVE_READ_REQUEST_FLAG        16
`define B_SLAVE_READ_UNDERFLOW_FLAG        17
`define B_SLAVE_WRITE_REQUEST_FLAG        18
`define B_SD          20
`define B_AL          24
`define FLAG_MASK     32'h0117_8000
`define CLR_MASK      32'h0115_8000
`define RST_WORD      32'h0000_0000
`define CTRL_EN       0
`define CTRL_ADDR_LSB 8
`define RST_OWN_ADDR  7'h50
`define ERR_TAG_NONE  4'h0
`define ERR_TAG_ARB   4'h8
`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2
`endif

// file: rtl/i2c_evt_pkg.sv
// Types shared by the event flag block and its bus monitor.
// Offsets and values live in i2c_evt_regs.svh.
package i2c_evt_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [2:0] {
      MON_IDLE = 3'b001,
      MON_ADDR = 3'b010,
      MON_DATA = 3'b100
   } mon_state_e;
endpackage

// file: rtl/bit_sync.sv
// Two-flop synchroniser for the two bus lines.
// Inputs are asynchronous pins; idle level is high.
`timescale 1ns/1ps
module bit_sync (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic [1:0] d,
   output wire logic [1:0] q
);
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else if (ce) begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate
endmodule // bit_sync

// file: rtl/i2c_bus_monitor.sv
// Watches the synchronised bus lines: start, stop and own-address hits.
// Lines must already be in the aclk domain.
`timescale 1ns/1ps
module i2c_bus_monitor
   import i2c_evt_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       en,
   input  wire logic [6:0] own_addr,
   output wire logic       start_p,
   output wire logic       stop_p,
   output wire logic       scl_rise_p,
   output wire logic       hit_rd_p,
   output wire logic       hit_wr_p,
   output wire logic       sel,
   output wire logic       slave_tx,
   output wire logic       busy
);
   mon_state_e state_q;
   logic       scl_q;
   logic       sda_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic       sel_q;
   logic       tx_q;
   logic       busy_q;
   logic [7:0] byte_now;
   logic       hit;

   assign scl_rise_p = scl & ~scl_q;
   assign start_p    = scl & scl_q & sda_q & ~sda;
   assign stop_p     = scl & scl_q & ~sda_q & sda;
   assign byte_now   = {sh_q[6:0], sda};
   assign hit        = (state_q == MON_ADDR) & scl_rise_p & (cnt_q == 4'h7)
                       & en & (byte_now[7:1] == own_addr);
   assign hit_rd_p   = hit & byte_now[0];
   assign hit_wr_p   = hit & ~byte_now[0];
   assign sel        = sel_q;
   assign slave_tx   = tx_q;
   assign busy       = busy_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Address byte is shifted in on rising clock edges after a start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= MON_IDLE;
         sh_q    <= 8'h00;
         cnt_q   <= 4'h0;
      end else if (ce) begin
         if (start_p) begin
            state_q <= MON_ADDR;
            cnt_q   <= 4'h0;
         end else if (stop_p) begin
            state_q <= MON_IDLE;
         end else begin
            case (state_q)
               MON_IDLE: state_q <= MON_IDLE;
               MON_ADDR: if (scl_rise_p) begin
                  sh_q  <= byte_now;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) state_q <= MON_DATA;
               end
               MON_DATA: state_q <= MON_DATA;
               default:  state_q <= MON_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_q  <= 1'b0;
         tx_q   <= 1'b0;
         busy_q <= 1'b0;
      end else if (ce) begin
         if (start_p | stop_p) begin
            sel_q <= 1'b0;
            tx_q  <= 1'b0;
         end else if (hit) begin
            sel_q <= 1'b1;
            tx_q  <= byte_now[0];
         end
         if (start_p) busy_q <= 1'b1;
         else if (stop_p) busy_q <= 1'b0;
      end
   end
endmodule // i2c_bus_monitor

// file: rtl/i2c_transaction_event_flags.sv
// Raw event flags of a two-wire bus controller, with AXI4-Lite register slave.
// Assumes open-drain pins with pull-ups, an outside TX FIFO and master engine.
// What this block does
// - Slave read address hit sets bit 16
// - Read request flushes the transmit FIFO
// - Read request clears on FIFO write or clear
// - Empty FIFO during slave read sets bit 17
// - Underflow clears on FIFO write or read end
// - Slave write address hit sets bit 18
// - Master done with stop sets bit 15
// - Master done pending withholds notices, stretches clock
// - Finished slave transaction sets bit 20
// - Slave done pending stretches, withholds notices
// - Lost arbitration sets bit 24 and tag
// - Released line sampled low: stop, wait stop
// - First zero against a one wins
// - Clear register ones clear flags except bit 17; reset zero
// - Mask bit one enables matching interrupt
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "i2c_evt_regs.svh"
module i2c_transaction_event_flags
   import i2c_evt_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output wire logic        wready,
   output wire logic [1:0]  bresp,
   output wire logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output wire logic        arready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   output wire logic        rvalid,
   input  wire logic        rready,
   input  wire logic        scl_i,
   output wire logic        scl_o,
   output wire logic        scl_oe_n,
   input  wire logic        sda_i,
   output wire logic        sda_o,
   output wire logic        sda_oe_n,
   input  wire logic        master_active,
   input  wire logic        master_sda_low,
   input  wire logic        master_done_stop,
   output wire logic        master_abort,
   output wire logic        master_retry,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_fifo_write,
   output wire logic        tx_flush,
   output wire logic        irq
);
   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       start_p;
   logic       stop_p;
   logic       scl_rise_p;
   logic       hit_rd_p;
   logic       hit_wr_p;
   logic       mon_sel;
   logic       mon_tx;
   logic       mon_busy;

   logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic       aw_got_q, w_got_q;
   logic [7:0] awaddr_q;
   word_t      wdata_q;
   logic [3:0] wstrb_q;
   logic       do_wr;
   logic [7:0] wa;
   logic [7:0] ra;
   word_t      wm;
   word_t      clr_bits;
   logic       rd_go;
   logic       rd_istat;
   word_t      rd_d;
   logic       rd_ok;

   word_t      mask_q;
   logic       en_q;
   logic [6:0] own_addr_q;
   logic       md_q, slave_read_request_flag_q, slave_read_underflow_flag_q, slave_write_request_flag_q, sd_q, al_q;
   logic       pend_rd_q, pend_wr_q;
   logic       hold;
   logic       deliver_rd, deliver_wr;
   logic       slave_end;
   logic       lose;
   logic       lost_q;
   logic [3:0] err_tag_q;
   word_t      raw;
   word_t      raw_prev_q;
   // Flag bits that may raise an interrupt status bit
   localparam word_t FLAG_BITS = `FLAG_MASK;
   word_t      istat_q;
   logic       irq_q;
   logic       flush_q, retry_q;
   logic       scl_oe_n_q, sda_oe_n_q;
   logic       low_q;

   function automatic word_t lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   bit_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       ({sda_i, scl_i}),
      .q       (pins_s)
   );
   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];

   i2c_bus_monitor u_mon (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .scl        (scl_s),
      .sda        (sda_s),
      .en         (en_q),
      .own_addr   (own_addr_q),
      .start_p    (start_p),
      .stop_p     (stop_p),
      .scl_rise_p (scl_rise_p),
      .hit_rd_p   (hit_rd_p),
      .hit_wr_p   (hit_wr_p),
      .sel        (mon_sel),
      .slave_tx   (mon_tx),
      .busy       (mon_busy)
   );

   // Write channel: address and data taken in either order
   assign do_wr = aw_got_q & w_got_q & ~bvalid_q;
   assign wa    = {awaddr_q[7:2], 2'b00};
   assign wm    = lanes(wstrb_q);
   assign clr_bits = (do_wr && wa == `OFS_CLR) ? (wdata_q & wm & `CLR_MASK) : `RST_WORD;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `AXI_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= `RST_WORD;
         wstrb_q   <= 4'h0;
      end else if (ce) begin
         if (awvalid && awready_q) begin
            awaddr_q  <= awaddr;
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= (wa == `OFS_MASK || wa == `OFS_CLR || wa == `OFS_CTRL) ?
                        `AXI_OKAY : `AXI_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q     <= `RST_WORD;
         en_q       <= 1'b0;
         own_addr_q <= `RST_OWN_ADDR;
      end else if (ce && do_wr) begin
         if (wa == `OFS_MASK) mask_q <= ((mask_q & ~wm) | (wdata_q & wm)) & `FLAG_MASK;
         if (wa == `OFS_CTRL && wstrb_q[0]) en_q <= wdata_q[`CTRL_EN];
         if (wa == `OFS_CTRL && wstrb_q[1]) own_addr_q <= wdata_q[`CTRL_ADDR_LSB +: 7];
      end
   end

   // Read channel: one cycle from address to data
   assign rd_go    = arvalid & arready_q;
   assign ra       = {araddr[7:2], 2'b00};
   assign rd_istat = rd_go & (ra == `OFS_ISTAT);

   always_comb begin
      rd_d  = `RST_WORD;
      rd_ok = 1'b1;
      case (ra)
         `OFS_MASK:  rd_d = mask_q;
         `OFS_RAW:   rd_d = raw;
         `OFS_ISTAT: rd_d = istat_q;
         `OFS_CLR:   rd_d = `RST_WORD;
         `OFS_CTRL:  rd_d = {17'h0_0000, own_addr_q, 7'h00, en_q};
         `OFS_STAT:  rd_d = {25'h000_0000, mon_tx, mon_busy, lost_q, err_tag_q};
         default:    rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= `RST_WORD;
         rresp_q   <= `AXI_OKAY;
      end else if (ce) begin
         if (rd_go) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_d;
            rresp_q   <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
         end else if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Notifications wait while a completion is unacknowledged
   assign hold       = md_q | sd_q;
   assign deliver_rd = pend_rd_q & ~hold;
   assign deliver_wr = pend_wr_q & ~hold;
   assign slave_end  = mon_sel & (stop_p | start_p);
   // Our line released, another station pulls it low and wins
   assign lose = master_active & ~master_sda_low & scl_rise_p & ~sda_s & ~lost_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_rd_q <= 1'b0;
         pend_wr_q <= 1'b0;
      end else if (ce) begin
         pend_rd_q <= hit_rd_p | (pend_rd_q & hold);
         pend_wr_q <= hit_wr_p | (pend_wr_q & hold);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slave_read_request_flag_q <= 1'b0;
         slave_read_underflow_flag_q <= 1'b0;
         slave_write_request_flag_q <= 1'b0;
         md_q   <= 1'b0;
         sd_q   <= 1'b0;
         al_q   <= 1'b0;
      end else if (ce) begin
         slave_read_request_flag_q <= deliver_rd | (slave_read_request_flag_q & ~tx_fifo_write & ~clr_bits[`B_SLAVE_READ_REQUEST_FLAG]);
         slave_read_underflow_flag_q <= mon_tx & tx_fifo_empty & ~tx_fifo_write;
         slave_write_request_flag_q <= deliver_wr | (slave_write_request_flag_q & ~clr_bits[`B_SLAVE_WRITE_REQUEST_FLAG]);
         md_q   <= master_done_stop | (md_q & ~clr_bits[`B_MD]);
         sd_q   <= slave_end | (sd_q & ~clr_bits[`B_SD]);
         al_q   <= lose | (al_q & ~clr_bits[`B_AL]);
      end
   end

   // Collision: stop driving, wait for a stop, then ask for a retry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lost_q    <= 1'b0;
         retry_q   <= 1'b0;
         err_tag_q <= `ERR_TAG_NONE;
      end else if (ce) begin
         retry_q <= lost_q & stop_p;
         if (lose) lost_q <= 1'b1;
         else if (stop_p) lost_q <= 1'b0;
         if (lose) err_tag_q <= `ERR_TAG_ARB;
         else if (clr_bits[`B_AL]) err_tag_q <= `ERR_TAG_NONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flush_q    <= 1'b0;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
         low_q      <= 1'b0;
      end else if (ce) begin
         low_q      <= 1'b0;
         flush_q    <= deliver_rd;
         scl_oe_n_q <= ~(hold & (pend_rd_q | pend_wr_q));
         sda_oe_n_q <= ~(master_active & master_sda_low & ~lost_q & ~lose);
      end
   end

   assign raw = {7'h00, al_q, 3'h0, sd_q, 1'b0, slave_write_request_flag_q, slave_read_underflow_flag_q, slave_read_request_flag_q, md_q, 15'h0000};

   // Sticky interrupt status per flag bit, cleared by reading it
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_istat
         always_ff @(posedge aclk) begin
            if (!aresetn) istat_q[gi] <= 1'b0;
            else if (ce) begin
               if (raw[gi] & ~raw_prev_q[gi] & FLAG_BITS[gi]) istat_q[gi] <= 1'b1;
               else if (rd_istat) istat_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_prev_q <= `RST_WORD;
         irq_q      <= 1'b0;
      end else if (ce) begin
         raw_prev_q <= raw;
         irq_q      <= |(istat_q & mask_q);
      end
   end

   assign awready      = awready_q;
   assign wready       = wready_q;
   assign bvalid       = bvalid_q;
   assign bresp        = bresp_q;
   assign arready      = arready_q;
   assign rvalid       = rvalid_q;
   assign rdata        = rdata_q;
   assign rresp        = rresp_q;
   assign scl_o        = low_q;
   assign sda_o        = low_q;
   assign scl_oe_n     = scl_oe_n_q;
   assign sda_oe_n     = sda_oe_n_q;
   assign master_abort = lost_q;
   assign master_retry = retry_q;
   assign tx_flush     = flush_q;
   assign irq          = irq_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rd_req;
      ce && deliver_rd |=> slave_read_request_flag_q && raw[`B_SLAVE_READ_REQUEST_FLAG];
   endproperty
   a_rd_req: assert property (p_rd_req) else $error("read request flag not set");
   property p_flush;
      ce && deliver_rd |=> tx_flush;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush on read request");
   property p_rd_self;
      ce && slave_read_request_flag_q && tx_fifo_write && !deliver_rd |=> !slave_read_request_flag_q;
   endproperty
   a_rd_self: assert property (p_rd_self) else $error("read request did not clear");
   property p_unf;
      ce && mon_tx && tx_fifo_empty && !tx_fifo_write |=> raw[`B_SLAVE_READ_UNDERFLOW_FLAG];
   endproperty
   a_unf: assert property (p_unf) else $error("underflow flag missing");
   property p_unf_end;
      ce && !mon_tx |=> !slave_read_underflow_flag_q;
   endproperty
   a_unf_end: assert property (p_unf_end) else $error("underflow kept after read");
   property p_wr_req;
      ce && deliver_wr |=> raw[`B_SLAVE_WRITE_REQUEST_FLAG];
   endproperty
   a_wr_req: assert property (p_wr_req) else $error("write request flag not set");
   property p_md;
      ce && master_done_stop |=> raw[`B_MD];
   endproperty
   a_md: assert property (p_md) else $error("master done not set");
   property p_stretch;
      ce && md_q && (pend_rd_q || pend_wr_q) |=> !scl_oe_n && !slave_read_request_flag_q[*1];
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock not stretched");
   property p_sd_hold;
      sd_q |-> !deliver_rd && !deliver_wr;
   endproperty
   a_sd_hold: assert property (p_sd_hold) else $error("notice leaked during slave done");
   property p_sd;
      ce && slave_end |=> raw[`B_SD];
   endproperty
   a_sd: assert property (p_sd) else $error("slave done not set");
   property p_al;
      ce && lose |=> raw[`B_AL] && err_tag_q == `ERR_TAG_ARB;
   endproperty
   a_al: assert property (p_al) else $error("arbitration loss not recorded");
   property p_release;
      ce && lose |=> sda_oe_n && master_abort throughout (!stop_p)[*2];
   endproperty
   a_release: assert property (p_release) else $error("bus not released");
   property p_clr;
      ce && clr_bits[`B_MD] && !master_done_stop |=> !raw[`B_MD];
   endproperty
   a_clr: assert property (p_clr) else $error("clear write ignored");
   property p_irq;
      ce |=> irq == $past(|(istat_q & mask_q));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not gated by mask");
   property p_set_wins;
      ce && clr_bits[`B_AL] && lose |=> al_q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

   c_rd: cover property (ce && deliver_rd ##1 tx_flush);
   c_lose: cover property (ce && lose);
   c_irq: cover property ($rose(irq));
   c_hold: cover property (ce && sd_q && pend_wr_q);
endmodule // i2c_transaction_event_flags

// file: test/i2c_far_master.sv
// Far-side bus station: start, address bytes and stop on open-drain lines.
// Assumes pull-ups on both lines, so a released line reads high.
`timescale 1ns/1ps
module i2c_far_master (
   input  wire logic scl_in,
   output logic      scl_p,
   output logic      sda_p
);
   initial begin
      scl_p = 1'b1;
      sda_p = 1'b1;
   end
   task automatic start;
      sda_p = 1'b0;
      #62;
      scl_p = 1'b0;
      #31;
   endtask
   // Waits, bounded, while the clock line is stretched low
   task automatic bit_out(input logic b);
      int i;
      sda_p = b;
      #31;
      scl_p = 1'b1;
      for (i = 0; i < 500 && scl_in !== 1'b1; i++) #8;
      #62;
      scl_p = 1'b0;
      #32;
   endtask
   task automatic send(input logic [7:0] v);
      for (int k = 7; k >= 0; k--) bit_out(v[k]);
      bit_out(1'b1);
   endtask
   task automatic stop;
      sda_p = 1'b0;
      #31;
      scl_p = 1'b1;
      #31;
      sda_p = 1'b1;
      #62;
   endtask
endmodule // i2c_far_master

// file: test/i2c_transaction_event_flags_test.sv
// Testbench: AXI4-Lite register tasks plus a far-side bus station.
// Bench stands in for the TX FIFO and the master engine.
`timescale 1ns/1ps
`include "i2c_evt_regs.svh"
module i2c_transaction_event_flags_test import i2c_evt_pkg::*;;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, master_active = 0, master_sda_low = 0;
   logic master_done_stop = 0, tx_fifo_empty = 1, tx_fifo_write = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [2:0] awprot = 0, arprot = 0;
   logic [3:0] wstrb = 4'hF;
   word_t      wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o;
   logic sda_oe_n, master_abort, master_retry, tx_flush, irq, scl_p, sda_p;
   wire logic scl_i = scl_p & scl_oe_n;
   wire logic sda_i = sda_p & sda_oe_n;
   int fail_count = 0, compares = 0, nflush = 0, nretry = 0;
   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      if (tx_flush === 1'b1) nflush++;
      if (master_retry === 1'b1) nretry++;
   end
   i2c_far_master far (.scl_in(scl_i), .scl_p(scl_p), .sda_p(sda_p));
   i2c_transaction_event_flags uut (.*);
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input word_t got, input word_t exp);
      compares++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 400) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input word_t d, input logic [1:0] er);
      int i;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 400; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      tmo(i);
      bready <= 0;
      chk(bresp, er);
   endtask
   task automatic rc(input logic [7:0] a, input word_t e, input logic [1:0] er);
      int i;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 400; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      tmo(i);
      chk(rdata, e);
      chk(rresp, er);
      rready <= 0;
   endtask
   // Write address arrives while a done flag holds notices back
   task automatic held(input word_t pend);
      int i;
      fork
         begin far.start(); far.send(8'hA0); end
         begin
            for (i = 0; i < 400 && scl_oe_n !== 1'b0; i++) @(posedge aclk);
            tmo(i);
            rc(`OFS_RAW, pend, 0);
            rc(`OFS_STAT, 32'h0000_0020, 0);
            wr(`OFS_CLR, pend, 0);
         end
      join
      rc(`OFS_RAW, 32'h0004_0000, 0);
      chk(scl_oe_n, 1);
      far.stop();
      rc(`OFS_RAW, 32'h0014_0000, 0);
   endtask
   initial begin
      cyc(4);
      aresetn <= 1;
      cyc(3);
      rc(`OFS_RAW, `RST_WORD, `AXI_OKAY);
      rc(8'h50, 0, `AXI_SLVERR);
      wr(`OFS_RAW, 32'hFFFF_FFFF, `AXI_SLVERR);
      wr(`OFS_CTRL, 32'h0000_5001, `AXI_OKAY);
      $display("test registers done");
      far.start();
      far.send(8'hA1);
      chk(nflush, 1);
      rc(`OFS_RAW, 32'h0003_0000, 0);
      wr(`OFS_CLR, 32'h0001_0000, 0);
      rc(`OFS_RAW, 32'h0002_0000, 0);
      @(posedge aclk) begin tx_fifo_write <= 1; tx_fifo_empty <= 0; end
      @(posedge aclk) tx_fifo_write <= 0;
      rc(`OFS_RAW, 0, 0);
      @(posedge aclk) tx_fifo_empty <= 1;
      rc(`OFS_RAW, 32'h0002_0000, 0);
      far.stop();
      rc(`OFS_RAW, 32'h0010_0000, 0);
      wr(`OFS_CLR, 32'h0010_0000, 0);
      $display("test slave read done");
      @(posedge aclk) master_done_stop <= 1;
      @(posedge aclk) master_done_stop <= 0;
      rc(`OFS_RAW, 32'h0000_8000, 0);
      chk(irq, 0);
      wr(`OFS_MASK, `FLAG_MASK, 0);
      cyc(2);
      chk(irq, 1);
      rc(`OFS_ISTAT, 32'h0013_8000, 0);
      cyc(2);
      chk(irq, 0);
      held(32'h0000_8000);
      wr(`OFS_CLR, 32'h0004_0000, 0);
      held(32'h0010_0000);
      wr(`OFS_CLR, 32'h0014_0000, 0);
      $display("test withheld notices done");
      @(posedge aclk) master_active <= 1;
      far.start();
      far.send(8'h00);
      chk(master_abort, 1);
      chk(sda_oe_n, 1);
      rc(`OFS_RAW, 32'h0100_0000, 0);
      rc(`OFS_STAT, 32'h0000_0038, 0);
      @(posedge aclk) master_active <= 0;
      far.stop();
      chk(nretry, 1);
      chk(master_abort, 0);
      wr(`OFS_CLR, 32'h0100_0000, 0);
      rc(`OFS_RAW, 0, 0);
      $display("test arbitration done");
      report_and_stop();
   end
endmodule // i2c_transaction_event_flags_test
